// [testbench/serial_control_port_asserts.sv]
/* Port-level checker for the serial control port.
   Assumes binding to the top module; sees only its ports. */
`timescale 1ns/1ns
module serial_control_port_asserts (
    // system
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // serial pins
    input wire logic SCLK,
    input wire logic SERIAL_SELECT_N,
    input wire logic PORT_SELECT_PIN,
    input wire logic SDO_OUT,
    input wire logic SDO_OE,
    // core bus
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic REG_READ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    logic sclk_d_reg;
    logic [3:0] since_rise_reg;
    // cycles since the clock pin rose, saturating
    always_ff @(posedge CLK_SYS) begin
        sclk_d_reg <= SCLK;
        if (!RESET_N) since_rise_reg <= 4'hf;
        else if (SCLK && !sclk_d_reg) since_rise_reg <= 4'h0;
        else if (since_rise_reg != 4'hf) since_rise_reg <= since_rise_reg + 4'h1;
    end
    a_sdo_pull_only: assert property (SDO_OUT == 1'b0)
        else $error("serial output drives high");
    a_idle_port_quiet: assert property (!PORT_SELECT_PIN [*4] |-> !SDO_OE && !REG_WRITE && !REG_READ)
        else $error("activity while deselected");
    a_deselect_release: assert property (SERIAL_SELECT_N [*5] |-> !SDO_OE)
        else $error("output held while deselected");
    a_sdo_on_rise: assert property ($changed(SDO_OE) && !SERIAL_SELECT_N |-> since_rise_reg <= 4'h5)
        else $error("output moved off a clock rise");
    a_write_after_rise: assert property ($rose(REG_WRITE) |-> since_rise_reg inside {[4'h1:4'h6]})
        else $error("write without a byte");
    a_write_pulse: assert property (REG_WRITE |=> !REG_WRITE)
        else $error("write strobe too long");
    a_read_pulse: assert property (REG_READ |=> !REG_READ)
        else $error("read strobe too long");
    a_no_rw_overlap: assert property (!(REG_WRITE && REG_READ))
        else $error("read and write strobes together");
    a_coeff_local: assert property (REG_WRITE || REG_READ |->
        !(REG_ADDR inside {8'h98, 8'h99, 8'h9c, 8'h9d, 8'h9e}))
        else $error("window address on core bus");
    c_write: cover property (REG_WRITE);
    c_read: cover property (REG_READ);
    c_readback: cover property ($rose(SDO_OE));
endmodule : serial_control_port_asserts
bind serial_control_port serial_control_port_asserts serial_control_port_asserts_inst (.*);

// [testbench/serial_host_model.sv]
/* Serial master model: one byte per call, either framing.
   Assumes clk is the system clock; one serial period is eight clks. */
`timescale 1ns/1ns
module serial_host_model (
    // pacing and straps
    input wire logic clk,
    input wire logic msb,
    input wire logic framed,
    input wire logic sdo_wire,
    // serial pins
    output logic sclk,
    output logic sdi,
    output logic sel_n,
    output logic rfs,
    output logic tfs
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b1;
        sel_n = 1'b1;
        rfs = 1'b0;
        tfs = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask : half
    // one byte each way; sel_hi loses it
    task automatic xfer(input logic [7:0] tx, input logic rd, input logic sel_hi,
                        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        @(posedge clk);
        sel_n <= sel_hi;
        if (framed) begin
            rfs <= !rd;
            tfs <= rd;
            sclk <= 1'b1;
            half();
            sclk <= 1'b0; // sync sampled on this fall
            half();
            rfs <= 1'b0;
            tfs <= 1'b0;
        end else begin
            rfs <= 1'($urandom); // noise the port must ignore
            tfs <= 1'($urandom);
        end
        // data moves on the fall, steady at the rise
        for (i = 0; i < 8; i++) begin
            sdi <= msb ? tx[7 - i] : tx[i];
            half();
            sclk <= 1'b1;
            half();
            rx = msb ? {rx[6:0], sdo_wire} : {sdo_wire, rx[7:1]};
            sclk <= 1'b0;
        end
        sdi <= msb ? ~tx[0] : ~tx[7]; // no stale bit
        half();
    endtask : xfer
    task automatic idle();
        @(posedge clk);
        sel_n <= 1'b1;
        half();
    endtask : idle
endmodule : serial_host_model

// [testbench/tb_serial_control_port.sv]
/* Self-checking bench for the serial control port.
   Assumes host model and checker compiled alongside. */
`timescale 1ns/1ns
`define CHECK(name, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb_serial_control_port;
    logic clk_sys, reset_n = 1'b0, port_sel = 1'b1, framed = 1'b0, msb = 1'b0;
    logic sclk, sdi, sel_n, rfs, tfs, sdo_out, sdo_oe, reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata, rx, tap_index = 8'h00;
    logic [15:0] got;
    logic [15:0] exp_q[$];
    logic [23:0] tap_data;
    int fails = 0, checked = 0;
    wire sdo_wire = sdo_oe ? sdo_out : 1'b1; // pull-up holds the released line high
    // core bus data must stand at the edge after the read strobe
    wire [7:0] reg_rdata = reg_read ? reg_addr ^ 8'h5a : 8'h00;
    serial_control_port serial_control_port_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .SCLK(sclk), .SDI(sdi), .SERIAL_SELECT_N(sel_n), .RECEIVE_FRAME_SYNC(rfs),
        .TRANSMIT_FRAME_SYNC(tfs), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
        .PORT_SELECT_PIN(port_sel), .FRAMED_SERIAL_MODE(framed), .MSB_FIRST(msb),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
        .REG_READ(reg_read), .REG_RDATA(reg_rdata), .COEFF_TAP_INDEX(tap_index),
        .COEFF_TAP_DATA(tap_data));
    serial_host_model serial_host_model_inst (.clk(clk_sys), .msb(msb), .framed(framed),
        .sdo_wire(sdo_wire), .sclk(sclk), .sdi(sdi), .sel_n(sel_n), .rfs(rfs), .tfs(tfs));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // writes are matched to the oldest note
    always @(posedge clk_sys) begin
        if (reg_write) begin
            got = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
            `CHECK("write", got, {reg_addr, reg_wdata})
        end
    end
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    function automatic logic [7:0] at(input logic [7:0] a, input int j);
        return msb ? a - 8'(j) : a + 8'(j);
    endfunction : at
    task automatic sendb(input logic [7:0] b);
        serial_host_model_inst.xfer(b, 1'b0, 1'b0, rx);
        serial_host_model_inst.idle();
    endtask : sendb
    // block write, select dropped per byte; bus: bytes reach the core bus
    task automatic wr(input logic [7:0] a, input int n, input logic [23:0] d, input logic bus);
        int j;
        sendb(a);
        sendb(8'(n));
        for (j = 0; j < n; j++) begin
            if (bus) exp_q.push_back({at(a, j), d[8*j +: 8]});
            sendb(d[8*j +: 8]);
        end
    endtask : wr
    // block read, select held low
    task automatic rd(input logic [7:0] a, input int n, input logic [23:0] d, input logic bus);
        int j;
        logic [7:0] e;
        serial_host_model_inst.xfer(a, 1'b0, 1'b0, rx);
        serial_host_model_inst.xfer(8'h80 | 8'(n), 1'b0, 1'b0, rx);
        for (j = 0; j < n; j++) begin
            e = bus ? at(a, j) ^ 8'h5a : d[8*j +: 8];
            serial_host_model_inst.xfer(8'hff, 1'b1, 1'b0, rx);
            `CHECK("readback", e, rx)
        end
        serial_host_model_inst.idle();
        `CHECK("released", 1'b0, sdo_oe)
    endtask : rd
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial begin
        int k;
        logic [23:0] w, d;
        void'($urandom(74));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // each bit order and framing: lost byte, block write, block read
        for (k = 0; k < 4; k++) begin
            msb <= k[0];
            framed <= k[1];
            serial_host_model_inst.xfer(8'h00, 1'b0, 1'b1, rx);
            serial_host_model_inst.idle();
            w = 24'(16 + $urandom_range(0, 100));
            wr(w[7:0], 2, 24'($urandom), 1'b1);
            rd(w[7:0], 2, 24'h0, 1'b1);
        end
        // coefficient word via the window, both byte orders
        for (k = 0; k < 2; k++) begin
            msb <= k[0];
            framed <= 1'b0;
            w = 24'($urandom);
            @(posedge clk_sys);
            d = msb ? {w[7:0], w[15:8], w[23:16]} : w;
            wr(8'h98, 1, 24'h0, 1'b0);
            wr(8'h99, 1, 24'h0, 1'b0);
            wr(msb ? 8'h9e : 8'h9c, 3, d, 1'b0);
            repeat (4) @(posedge clk_sys);
            `CHECK("tap", w, tap_data)
            wr(8'h98, 1, 24'h0, 1'b0);
            rd(msb ? 8'h9e : 8'h9c, 3, d, 1'b0);
        end
        port_sel <= 1'b0;
        wr(8'h40, 1, 24'h5, 1'b0);
        port_sel <= 1'b1;
        repeat (20) @(posedge clk_sys);
        `CHECK("pending writes", 0, exp_q.size())
        complete_run();
    end
endmodule : tb_serial_control_port

// [verilog/serial_control_port.sv]
/*
 * Serial control port: byte sequencer and coefficient window.
 * Assumes the core bus answers a read strobe by the next clock.
 */
`timescale 1ns/1ns
module serial_control_port (
    // system
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // serial link pins
    input wire logic SCLK,
    input wire logic SDI,
    input wire logic SERIAL_SELECT_N,
    input wire logic RECEIVE_FRAME_SYNC,
    input wire logic TRANSMIT_FRAME_SYNC,
    output logic SDO_OUT,
    output logic SDO_OE,
    // configuration straps
    input wire logic PORT_SELECT_PIN,
    input wire logic FRAMED_SERIAL_MODE,
    input wire logic MSB_FIRST,
    // core register bus
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WRITE,
    output logic REG_READ,
    input wire logic [7:0] REG_RDATA,
    // coefficient tap for the datapath
    input wire logic [7:0] COEFF_TAP_INDEX,
    output logic [23:0] COEFF_TAP_DATA
);
    serial_link_if link ();

    serial_port_pkg::xfer_state_t state_reg;
    logic [7:0] addr_reg;
    logic [6:0] count_reg;
    logic fetch_reg;
    logic bus_read_reg;
    logic local_hit_reg;
    logic [7:0] local_byte_reg;
    logic [7:0] tx_byte_reg;
    logic tx_load_reg;
    logic [7:0] start_reg;
    logic [7:0] final_reg;
    logic [7:0] index_reg;
    logic [7:0] low_reg;
    logic [7:0] mid_reg;
    logic [7:0] high_reg;
    logic [serial_port_pkg::COEFF_WIDTH-1:0] coeff_ram [serial_port_pkg::COEFF_DEPTH];
    logic [serial_port_pkg::COEFF_WIDTH-1:0] coeff_word;
    logic [7:0] local_byte;
    logic msb;
    logic rx;
    logic [7:0] rx_byte;
    logic write_byte;
    logic fetch_next;
    logic local_write;
    logic local_read;
    logic [7:0] index_next;

    // pins and bit shifting; bytes arrive as core-clock pulses
    serial_shifter u_shifter (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .sclk(SCLK),
        .sdi(SDI),
        .select_n(SERIAL_SELECT_N),
        .rx_sync(RECEIVE_FRAME_SYNC),
        .tx_sync(TRANSMIT_FRAME_SYNC),
        .port_sel(PORT_SELECT_PIN),
        .framed(FRAMED_SERIAL_MODE),
        .msb_pin(MSB_FIRST),
        .sdo_oe(SDO_OE),
        .link(link.shifter)
    ); // R27

    // open drain: level fixed low, only the enable moves
    assign SDO_OUT = 1'b0; // R25

    assign msb = link.msb_first;
    assign rx = link.rx_valid;
    assign rx_byte = link.rx_byte;
    assign link.tx_byte = tx_byte_reg;
    assign link.tx_load = tx_load_reg;

    // a data byte arriving in the write phase
    assign write_byte = rx && (state_reg == serial_port_pkg::ST_WRITE);
    assign local_write = write_byte && serial_port_pkg::is_local(addr_reg);

    // fetch after a read instruction or each byte but the last
    assign fetch_next = (rx && state_reg == serial_port_pkg::ST_INSTR
                         && rx_byte[serial_port_pkg::READ_FLAG_BIT]
                         && rx_byte[serial_port_pkg::COUNT_MSB:0] != 7'h00)
                     || (link.tx_done && state_reg == serial_port_pkg::ST_READ
                         && count_reg != 7'h01);
    assign local_read = fetch_reg && serial_port_pkg::is_local(addr_reg);

    // index saturates at final rather than wrapping into unused taps
    assign index_next = (index_reg == final_reg) ? index_reg : index_reg + 8'h01;

    // readback of the local window
    assign coeff_word = coeff_ram[index_reg];
    always_comb begin
        case (addr_reg)
            serial_port_pkg::COEFF_START_ADDR: local_byte = start_reg;
            serial_port_pkg::COEFF_FINAL_ADDR: local_byte = final_reg;
            serial_port_pkg::COEFF_LOW_ADDR: local_byte = coeff_word[7:0];
            serial_port_pkg::COEFF_MID_ADDR: local_byte = coeff_word[15:8];
            serial_port_pkg::COEFF_HIGH_ADDR: local_byte = coeff_word[23:16];
            default: local_byte = serial_port_pkg::BYTE_RESET;
        endcase
    end

    // sequencer: address, instruction, counted data
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N || !link.port_active) begin
            state_reg <= serial_port_pkg::ST_ADDR; // R6
            addr_reg <= serial_port_pkg::BYTE_RESET;
            count_reg <= 7'h00;
        end else begin
            case (state_reg)
                serial_port_pkg::ST_ADDR: begin
                    if (rx) begin
                        // block start when lsb-first, block end when msb-first
                        addr_reg <= rx_byte; // R4 R12
                        state_reg <= serial_port_pkg::ST_INSTR;
                    end
                end
                serial_port_pkg::ST_INSTR: begin
                    if (rx) begin
                        count_reg <= rx_byte[serial_port_pkg::COUNT_MSB:0]; // R22 R24
                        if (rx_byte[serial_port_pkg::COUNT_MSB:0] == 7'h00)
                            state_reg <= serial_port_pkg::ST_ADDR;
                        else if (rx_byte[serial_port_pkg::READ_FLAG_BIT])
                            state_reg <= serial_port_pkg::ST_READ; // R21 R22
                        else
                            state_reg <= serial_port_pkg::ST_WRITE; // R21
                    end
                end
                serial_port_pkg::ST_WRITE: begin
                    if (rx) begin
                        addr_reg <= serial_port_pkg::step_addr(addr_reg, msb); // R23
                        count_reg <= count_reg - 7'h01;
                        if (count_reg == 7'h01)
                            state_reg <= serial_port_pkg::ST_ADDR; // R26
                    end
                end
                serial_port_pkg::ST_READ: begin
                    if (link.tx_done) begin
                        addr_reg <= serial_port_pkg::step_addr(addr_reg, msb); // R23
                        count_reg <= count_reg - 7'h01;
                        if (count_reg == 7'h01)
                            state_reg <= serial_port_pkg::ST_ADDR; // R26
                    end
                end
                default: state_reg <= serial_port_pkg::ST_ADDR;
            endcase
        end
    end

    // fetch pipeline; one clock lets a stepped address settle
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            fetch_reg <= 1'b0;
            bus_read_reg <= 1'b0;
            local_hit_reg <= 1'b0;
            local_byte_reg <= serial_port_pkg::BYTE_RESET;
            tx_byte_reg <= serial_port_pkg::BYTE_RESET;
            tx_load_reg <= 1'b0;
        end else begin
            fetch_reg <= fetch_next;
            bus_read_reg <= fetch_reg && !local_read;
            local_hit_reg <= local_read;
            local_byte_reg <= local_byte;
            tx_load_reg <= local_hit_reg || bus_read_reg;
            if (local_hit_reg)
                tx_byte_reg <= local_byte_reg;
            else if (bus_read_reg)
                tx_byte_reg <= REG_RDATA;
        end
    end

    // core bus: one strobe per byte outside the local window
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            REG_ADDR <= serial_port_pkg::BYTE_RESET;
            REG_WDATA <= serial_port_pkg::BYTE_RESET;
            REG_WRITE <= 1'b0;
            REG_READ <= 1'b0;
        end else begin
            REG_WRITE <= write_byte && !local_write; // R11
            REG_READ <= fetch_reg && !local_read;
            if (write_byte || fetch_reg)
                REG_ADDR <= addr_reg;
            if (write_byte)
                REG_WDATA <= rx_byte;
        end
    end

    // coefficient window registers and index walk
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            start_reg <= serial_port_pkg::COEFF_START_RESET;
            final_reg <= serial_port_pkg::COEFF_FINAL_RESET;
            index_reg <= serial_port_pkg::COEFF_START_RESET;
            low_reg <= serial_port_pkg::BYTE_RESET;
            mid_reg <= serial_port_pkg::BYTE_RESET;
            high_reg <= serial_port_pkg::BYTE_RESET;
        end else if (local_write) begin
            case (addr_reg)
                serial_port_pkg::COEFF_START_ADDR: begin
                    start_reg <= rx_byte; // R19
                    index_reg <= rx_byte;
                end
                serial_port_pkg::COEFF_FINAL_ADDR: final_reg <= rx_byte; // R19
                serial_port_pkg::COEFF_LOW_ADDR: low_reg <= rx_byte; // R20
                serial_port_pkg::COEFF_MID_ADDR: mid_reg <= rx_byte; // R20
                serial_port_pkg::COEFF_HIGH_ADDR: high_reg <= rx_byte; // R20
                default: ;
            endcase
            // word completes on the last byte in bit order
            if (addr_reg == serial_port_pkg::last_coeff_addr(msb))
                index_reg <= index_next; // R4 R20
        end else if (local_read && addr_reg == serial_port_pkg::last_coeff_addr(msb)) begin
            index_reg <= index_next; // R4 R20
        end
    end

    // store; completing byte merged straight in
    always_ff @(posedge CLK_SYS) begin
        if (local_write && addr_reg == serial_port_pkg::last_coeff_addr(msb)) begin
            if (msb)
                coeff_ram[index_reg] <= {high_reg, mid_reg, rx_byte}; // R20
            else
                coeff_ram[index_reg] <= {rx_byte, mid_reg, low_reg}; // R20
        end
    end

    // datapath tap read, registered
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            COEFF_TAP_DATA <= 24'h000000;
        else
            COEFF_TAP_DATA <= coeff_ram[COEFF_TAP_INDEX];
    end

endmodule : serial_control_port

// [verilog/serial_link_if.sv]
/*
 * Byte hand-off between shifter and sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface serial_link_if;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [7:0] tx_byte;
    logic tx_load;
    logic tx_done;
    logic msb_first;
    logic port_active;

    modport shifter (output rx_byte, output rx_valid, input tx_byte, input tx_load,
                     output tx_done, output msb_first, output port_active);
    modport control (input rx_byte, input rx_valid, output tx_byte, output tx_load,
                     input tx_done, input msb_first, input port_active);
endinterface : serial_link_if

// [verilog/serial_port_pkg.sv]
/*
 * Constants, states and helpers for the serial control port.
 * Assumes: one system clock; serial pins are sampled, never clocks.
 */
// What this block does
// R1 - serial input sampled on each serial clock rise
// R2 - readback bits launched on serial clock rises
// R3 - bit-order pin: 1 msb first, 0 lsb first
// R4 - bit order also picks block start or end and coefficient order
// R5 - mode pin: 0 chip-select framing, 1 frame-sync framing
// R6 - serial port works only while port-select pin is high
// R7 - chip-select framing ignores both frame syncs
// R8 - chip select is active low
// R9 - host clocks only with select low; stray clocks still shift
// R10 - select may drop per byte or stay low per block; readback clears while select is high, so reads need it held low
// R11 - eight bits collected before a byte reaches the bus
// R12 - a read opens with address byte, then instruction byte
// R13 - serial output released except while readback shifts
// R14 - framed mode: free-running clock, syncs mark bytes
// R15 - frame syncs sampled on serial clock falls
// R16 - framed units are eight bits from the rise after a sync
// R17 - host raises transmit sync once per readback byte
// R18 - framed write: select low, receive sync, eight bits
// R19 - coefficient start index 0x98, final index 0x99
// R20 - coefficient bytes 0x9c to 0x9e; top byte first if msb-first
// R21 - instruction 0x01 writes one byte, 0x81 reads one
// R22 - instruction: bit 7 read flag, bits 6..0 byte count
// R23 - block address rises lsb-first, falls msb-first
// R24 - up to 127 data bytes per address and instruction
// R25 - serial output open drain, pulls low only
// R26 - count exhausted: next byte is a new address
// R27 - serial bytes synchronised to core clock first
package serial_port_pkg;

    // coefficient window addresses
    localparam logic [7:0] COEFF_START_ADDR = 8'h98;
    localparam logic [7:0] COEFF_FINAL_ADDR = 8'h99;
    localparam logic [7:0] COEFF_LOW_ADDR = 8'h9c;
    localparam logic [7:0] COEFF_MID_ADDR = 8'h9d;
    localparam logic [7:0] COEFF_HIGH_ADDR = 8'h9e;

    // reset values
    localparam logic [7:0] COEFF_START_RESET = 8'h00;
    localparam logic [7:0] COEFF_FINAL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // instruction layout
    localparam int READ_FLAG_BIT = 7;
    localparam int COUNT_MSB = 6;

    // framing and storage sizes
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int COEFF_WIDTH = 24;
    localparam int COEFF_DEPTH = 256;

    typedef enum logic [1:0] {
        ST_ADDR = 2'b00,
        ST_INSTR = 2'b01,
        ST_WRITE = 2'b11,
        ST_READ = 2'b10
    } xfer_state_t;

    // one bit in, chosen order
    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                            input logic msb_first);
        shift_in = msb_first ? {sr[6:0], b} : {b, sr[7:1]};
    endfunction : shift_in

    // bit that leaves next
    function automatic logic first_bit(input logic [7:0] sr, input logic msb_first);
        first_bit = msb_first ? sr[7] : sr[0];
    endfunction : first_bit

    // register after one bit leaves
    function automatic logic [7:0] shift_out(input logic [7:0] sr, input logic msb_first);
        shift_out = msb_first ? {sr[6:0], 1'b0} : {1'b0, sr[7:1]};
    endfunction : shift_out

    // block address step
    function automatic logic [7:0] step_addr(input logic [7:0] a, input logic msb_first);
        step_addr = msb_first ? a - 8'h01 : a + 8'h01;
    endfunction : step_addr

    // byte that completes a word
    function automatic logic [7:0] last_coeff_addr(input logic msb_first);
        last_coeff_addr = msb_first ? COEFF_LOW_ADDR : COEFF_HIGH_ADDR;
    endfunction : last_coeff_addr

    function automatic logic is_coeff_data(input logic [7:0] a);
        is_coeff_data = (a == COEFF_LOW_ADDR) || (a == COEFF_MID_ADDR)
                     || (a == COEFF_HIGH_ADDR);
    endfunction : is_coeff_data

    function automatic logic is_local(input logic [7:0] a);
        is_local = is_coeff_data(a) || (a == COEFF_START_ADDR) || (a == COEFF_FINAL_ADDR);
    endfunction : is_local

endpackage : serial_port_pkg

// [verilog/serial_shifter.sv]
/*
 * Pin side: synchronisers, serial clock edge finder, byte shifting.
 * Assumes the serial clock is at least four system clocks per half period.
 */
`timescale 1ns/1ns
module serial_shifter (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // serial pins, all asynchronous
    input wire logic sclk,
    input wire logic sdi,
    input wire logic select_n,
    input wire logic rx_sync,
    input wire logic tx_sync,
    input wire logic port_sel,
    input wire logic framed,
    input wire logic msb_pin,
    // open-drain pull-down enable
    output logic sdo_oe,
    // byte side
    serial_link_if.shifter link
);
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;
    logic sclk_prev_reg;
    logic [7:0] rx_sr_reg;
    logic [3:0] rx_cnt_reg;
    logic rx_run_reg;
    logic tx_arm_reg;
    logic tx_pend_reg;
    logic [7:0] tx_hold_reg;
    logic [7:0] tx_sr_reg;
    logic [3:0] tx_cnt_reg;
    logic s_clk, s_sdi, s_sel_n, s_rfs, s_tfs, s_port, s_framed, s_msb;
    logic rise, fall, rx_take, tx_start;

    // two stages per pin; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
            sclk_prev_reg <= 1'b0;
        end else begin
            meta_reg <= {sclk, sdi, select_n, rx_sync, tx_sync, port_sel, framed, msb_pin};
            sync_reg <= meta_reg;
            sclk_prev_reg <= sync_reg[7];
        end
    end

    assign {s_clk, s_sdi, s_sel_n, s_rfs, s_tfs, s_port, s_framed, s_msb} = sync_reg;
    assign rise = s_port && s_clk && !sclk_prev_reg; // R6
    assign fall = s_port && !s_clk && sclk_prev_reg;
    assign link.msb_first = s_msb;
    assign link.port_active = s_port;

    // chip-select framing shifts every rise, framed only after a sync
    assign rx_take = rise && (!s_framed || rx_run_reg); // R1 R5 R9
    // transmit starts on a byte boundary or after a transmit sync
    assign tx_start = rise && !s_sel_n && tx_pend_reg
                   && (s_framed ? tx_arm_reg : rx_cnt_reg == 4'h0); // R5 R10 R16

    // frame syncs caught on falls, framed mode only
    always_ff @(posedge clk) begin
        if (!reset_n || !s_framed) begin
            rx_run_reg <= 1'b0; // R7
            tx_arm_reg <= 1'b0;
        end else begin
            if (fall && s_rfs && !s_sel_n)
                rx_run_reg <= 1'b1; // R15 R18
            else if (rx_take && rx_cnt_reg == serial_port_pkg::BITS_PER_BYTE - 4'h1)
                rx_run_reg <= 1'b0;
            if (fall && s_tfs && !s_sel_n)
                tx_arm_reg <= 1'b1; // R15 R17
            else if (rise)
                tx_arm_reg <= 1'b0;
        end
    end

    // receive shifter; counter wraps every eight bits
    always_ff @(posedge clk) begin
        if (!reset_n || !s_port) begin
            rx_sr_reg <= serial_port_pkg::BYTE_RESET;
            rx_cnt_reg <= 4'h0;
            link.rx_valid <= 1'b0;
            link.rx_byte <= serial_port_pkg::BYTE_RESET;
        end else begin
            link.rx_valid <= 1'b0;
            if (rx_take) begin
                rx_sr_reg <= serial_port_pkg::shift_in(rx_sr_reg, s_sdi, s_msb); // R3
                if (rx_cnt_reg == serial_port_pkg::BITS_PER_BYTE - 4'h1) begin
                    rx_cnt_reg <= 4'h0;
                    // a byte clocked with select high is lost
                    link.rx_valid <= !s_sel_n; // R8 R11
                    link.rx_byte <= serial_port_pkg::shift_in(rx_sr_reg, s_sdi, s_msb);
                end else begin
                    rx_cnt_reg <= rx_cnt_reg + 4'h1;
                end
            end
        end
    end

    // readback shifter; pulls low only for zero bits
    always_ff @(posedge clk) begin
        if (!reset_n || !s_port || s_sel_n) begin
            tx_pend_reg <= 1'b0;
            tx_hold_reg <= serial_port_pkg::BYTE_RESET;
            tx_sr_reg <= serial_port_pkg::BYTE_RESET;
            tx_cnt_reg <= 4'h0;
            sdo_oe <= 1'b0; // R13
            link.tx_done <= 1'b0;
        end else begin
            link.tx_done <= 1'b0;
            if (link.tx_load) begin
                tx_pend_reg <= 1'b1;
                tx_hold_reg <= link.tx_byte;
            end else if (tx_start) begin
                tx_pend_reg <= 1'b0;
            end
            if (tx_start) begin
                sdo_oe <= !serial_port_pkg::first_bit(tx_hold_reg, s_msb); // R2 R3 R25
                tx_sr_reg <= serial_port_pkg::shift_out(tx_hold_reg, s_msb);
                tx_cnt_reg <= serial_port_pkg::BITS_PER_BYTE - 4'h1;
            end else if (rise && tx_cnt_reg != 4'h0) begin
                sdo_oe <= !serial_port_pkg::first_bit(tx_sr_reg, s_msb); // R2 R25
                tx_sr_reg <= serial_port_pkg::shift_out(tx_sr_reg, s_msb);
                tx_cnt_reg <= tx_cnt_reg - 4'h1;
                link.tx_done <= (tx_cnt_reg == 4'h1);
            end else if (rise) begin
                sdo_oe <= 1'b0; // R13
            end
        end
    end

endmodule : serial_shifter
